// File: hdl/sdf_pkg.sv
// Shared constants and types of the sigma-delta decimation filter.
package sdf_pkg;

    // ----------------------------------------------------------------
    // Register map and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DATA   = 8'h08;
    localparam int         ST_AVAIL    = 0;
    localparam int         ST_OVERRUN  = 1;
    localparam int         ST_BYPASS   = 2;
    localparam int         ST_EXTCLK   = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Modes and configuration
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_DUTY   = 2'b01,
        MODE_TURBO  = 2'b10
    } sdf_mode_t;

    typedef enum logic [1:0] {
        REJ_NONE = 2'b00,
        REJ_BOTH = 2'b01,
        REJ_50   = 2'b10,
        REJ_60   = 2'b11
    } sdf_rej_t;

    // Control word: mode [1:0], rate [4:2], rejection [6:5], gain [9:7],
    // amp_bypass [10], start [11].
    typedef struct packed {
        logic       start;
        logic       amp_bypass;
        logic [2:0] gain;
        logic [1:0] rej;
        logic [2:0] rate;
        logic [1:0] mode;
    } sdf_cfg_t;

    localparam sdf_cfg_t   CFG_RESET    = 12'h000;
    localparam logic [2:0] GAIN_MAX_BYP = 3'h2;

    // ----------------------------------------------------------------
    // Clock division and decimation lengths
    // ----------------------------------------------------------------
    localparam logic [4:0]  DIV_NORMAL = 5'h10;
    localparam logic [4:0]  DIV_TURBO  = 5'h08;
    localparam logic [1:0]  DUTY_IDLE  = 2'h3;
    localparam int          SAMPLE_W   = 24;
    localparam int          ACC_W      = 16;
    // Modulator samples per result, one entry per rate code.
    localparam logic [14:0] DEC_LEN [0:7] = '{
        15'h3200, 15'h1639, 15'h0B1C, 15'h05B7,
        15'h0308, 15'h01AB, 15'h0100, 15'h0100
    };
    localparam logic [14:0] DEC_BOTH  = 15'h6400;
    localparam logic [14:0] DEC_50    = 15'h3C00;
    localparam logic [14:0] DEC_60    = 15'h3200;

endpackage : sdf_pkg

// File: hdl/sdf_buf.sv
// Two-entry elastic buffer between the filter result and the data register.
`timescale 1ns/10ps
module sdf_buf (
    // Clock and reset
    input  logic                         clk,
    input  logic                         rst_n,
    // Filling side
    input  logic                         in_valid,
    output logic                         in_ready,
    input  logic [sdf_pkg::SAMPLE_W-1:0] in_data,
    // Draining side
    output logic                         out_valid,
    input  logic                         out_ready,
    output logic [sdf_pkg::SAMPLE_W-1:0] out_data
);

    logic [sdf_pkg::SAMPLE_W-1:0] mem [0:1];
    logic                         wr_ptr;
    logic                         rd_ptr;
    logic [1:0]                   count;
    wire                          push = in_valid && in_ready;
    wire                          pop  = out_valid && out_ready;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            count  <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
        count == 2'h2 |-> !push) else $error("buffer written while full");

endmodule : sdf_buf

// File: hdl/sdf_top.sv
// Decimation filter, modulator clock strobe and amplifier control behind AXI4-Lite.
//
// Notes on behaviour
// - Modulator strobe every 16 system clocks, every 8 in turbo mode.
// - Divider runs on the active system clock, oscillator or external.
// - Linear-phase FIR low-pass filters and decimates the bitstream to the rate.
// - Filter retunes per rate; each result settles in one conversion, a held one replaced on overrun.
// - Line rejection choice applies only at the lowest rate (rate code 0), outside turbo mode.
// - A two-bit field selects none, both, 50 Hz or 60 Hz rejection.
// - Notches and data rate scale linearly with the system clock.
// - Amplifier bypass honoured only for gains 1, 2 and 4.
// - Bypass disables the amplifier and selects the switched-capacitor gain stage.
`timescale 1ns/10ps
module sdf_top (
    // Clock and reset
    input  logic        clk,
    input  logic        rst_n,
    // AXI4-Lite write address and data
    input  logic [7:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    // AXI4-Lite read
    input  logic [7:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    // Modulator
    input  logic        mod_bit,
    output logic        mod_clk_en,
    // Clock source status
    input  logic        ext_clk_active,
    // Analog front end control
    output logic        amp_bypass,
    output logic        low_noise_amp_en,
    output logic [2:0]  gain
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [14:0] dec_len(input sdf_pkg::sdf_cfg_t c);
        logic low;
        low = (c.rate == 3'h0) && (c.mode != sdf_pkg::MODE_TURBO);
        if (!low) begin
            dec_len = sdf_pkg::DEC_LEN[c.rate];
        end else begin
            case (c.rej)
                sdf_pkg::REJ_BOTH: dec_len = sdf_pkg::DEC_BOTH;
                sdf_pkg::REJ_50:   dec_len = sdf_pkg::DEC_50;
                sdf_pkg::REJ_60:   dec_len = sdf_pkg::DEC_60;
                default:           dec_len = sdf_pkg::DEC_LEN[3'h0];
            endcase
        end
    endfunction : dec_len

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[8*i +: 8] = nw[8*i +: 8];
            end
        end
    endfunction : merge

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    sdf_pkg::sdf_cfg_t cfg;
    logic [7:0]        aw_addr;
    logic              aw_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_got;
    logic              overrun;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;

    wire do_wr     = aw_got && w_got && !s_axi_bvalid;
    wire wr_ctrl   = do_wr && (aw_addr == sdf_pkg::ADDR_CTRL);
    wire wr_status = do_wr && (aw_addr == sdf_pkg::ADDR_STATUS);
    wire wr_ok     = wr_ctrl || wr_status;
    wire rd_fire   = s_axi_arvalid && s_axi_arready;
    wire rd_data   = rd_fire && (s_axi_araddr == sdf_pkg::ADDR_DATA);
    wire clr_ovr   = wr_status && w_strb[0] && w_data[sdf_pkg::ST_OVERRUN];
    wire [31:0] ctrl_merged = merge({20'h00000, cfg}, w_data, w_strb);

    assign s_axi_awready = !aw_got;
    assign s_axi_wready  = !w_got;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_got  <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && !aw_got) begin
            aw_got  <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_got  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_got  <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && !w_got) begin
            w_got  <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_wr) begin
            w_got  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= sdf_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? sdf_pkg::RESP_OKAY : sdf_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg <= sdf_pkg::CFG_RESET;
        end else if (wr_ctrl) begin
            cfg <= ctrl_merged[11:0];
        end
    end

    // ----------------------------------------------------------------
    // Front end control
    // ----------------------------------------------------------------
    // A bypass request at gains above 4 is held in the register but not
    // acted on, so the amplifier stays in the path where it is needed.
    wire bypass_ok = cfg.amp_bypass && (cfg.gain <= sdf_pkg::GAIN_MAX_BYP);
    assign amp_bypass       = bypass_ok;
    assign low_noise_amp_en = !bypass_ok;
    assign gain             = cfg.gain;

    // ----------------------------------------------------------------
    // Modulator clock strobe
    // ----------------------------------------------------------------
    // Runs on clk, which is whichever system clock is active, so the rate,
    // the notches and the result rate all follow its frequency.
    logic [1:0] mode_q;
    logic [3:0] div_cnt;
    wire        turbo    = (cfg.mode == sdf_pkg::MODE_TURBO);
    wire  [4:0] div      = turbo ? sdf_pkg::DIV_TURBO : sdf_pkg::DIV_NORMAL;
    wire        mode_chg = (mode_q != cfg.mode);
    wire  [3:0] div_last = 4'(div - 5'h01);

    assign mod_clk_en = (div_cnt == 4'h0) && !mode_chg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q  <= sdf_pkg::MODE_NORMAL;
            div_cnt <= 4'h0;
        end else begin
            mode_q  <= cfg.mode;
            div_cnt <= (mode_chg || div_cnt == 4'h0) ? div_last : div_cnt - 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Decimation filter
    // ----------------------------------------------------------------
    // A boxcar over a whole conversion is linear phase and settles in one
    // conversion; its notches fall at the result rate and its multiples.
    logic signed [sdf_pkg::ACC_W-1:0] acc;
    logic [14:0]                      n_cnt;
    logic [1:0]                       idle;
    logic [sdf_pkg::SAMPLE_W-1:0]     result;
    logic                             res_valid;
    logic                             buf_ready;
    logic                             buf_valid;
    logic [sdf_pkg::SAMPLE_W-1:0]     buf_data;

    wire [14:0] cur_len  = dec_len(cfg);
    wire        run      = cfg.start && mod_clk_en;
    wire        last     = (n_cnt == cur_len - 15'h0001);
    wire        dec_done = run && last && (idle == 2'h0);
    wire signed [sdf_pkg::ACC_W-1:0] step = mod_bit ? 16'sh0001 : -16'sh0001;
    wire signed [sdf_pkg::ACC_W-1:0] acc_sum = acc + step;
    wire        duty     = (cfg.mode == sdf_pkg::MODE_DUTY);

    always_ff @(posedge clk) begin
        if (!rst_n || wr_ctrl) begin
            acc   <= '0;
            n_cnt <= 15'h0000;
            idle  <= 2'h0;
        end else if (run) begin
            acc   <= (last || idle != 2'h0) ? '0 : acc_sum;
            n_cnt <= last ? 15'h0000 : n_cnt + 15'h0001;
            if (last) begin
                idle <= (idle != 2'h0) ? idle - 2'h1 : (duty ? sdf_pkg::DUTY_IDLE : 2'h0);
            end
        end
    end

    // The held result waits for the buffer; a new one arriving before it
    // moves on is taken in its place and flagged as an overrun.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
            result    <= '0;
        end else if (dec_done) begin
            res_valid <= 1'b1;
            result    <= {{(sdf_pkg::SAMPLE_W-sdf_pkg::ACC_W){acc_sum[15]}}, acc_sum};
        end else if (buf_ready) begin
            res_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overrun <= 1'b0;
        end else if (dec_done && res_valid && !buf_ready) begin
            overrun <= 1'b1;
        end else if (clr_ovr) begin
            overrun <= 1'b0;
        end
    end

    sdf_buf u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (res_valid),
        .in_ready  (buf_ready),
        .in_data   (result),
        .out_valid (buf_valid),
        .out_ready (rd_data),
        .out_data  (buf_data)
    );

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    wire [31:0] status_word = {28'h0000000, ext_clk_active, bypass_ok, overrun,
                               buf_valid};

    always_comb begin
        next_rdata = 32'h00000000;
        next_rresp = sdf_pkg::RESP_OKAY;
        case (s_axi_araddr)
            sdf_pkg::ADDR_CTRL:   next_rdata = {20'h00000, cfg};
            sdf_pkg::ADDR_STATUS: next_rdata = status_word;
            sdf_pkg::ADDR_DATA:   next_rdata = {8'h00, buf_data};
            default:              next_rresp = sdf_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= sdf_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    turbo_div_a: assert property (
        (mod_clk_en && turbo) ##1 (!mode_chg && turbo)[*8] |-> mod_clk_en)
        else $error("turbo strobe not every 8 clocks");
    normal_div_a: assert property (
        (mod_clk_en && !turbo) ##1 (!mode_chg && !turbo)[*7] |-> !mod_clk_en)
        else $error("normal strobe faster than 16 clocks");
    reload_a: assert property (
        mode_chg |-> !mod_clk_en ##1 (div_cnt == div_last))
        else $error("divider not reloaded on mode change");
    result_len_a: assert property (
        dec_done |-> n_cnt == cur_len - 15'h0001)
        else $error("result before full conversion length");
    restart_a: assert property (
        wr_ctrl |=> acc == '0 && n_cnt == 15'h0000 && !dec_done)
        else $error("filter not restarted on reconfiguration");
    rej_scope_a: assert property (
        (cfg.rate != 3'h0 || turbo) |-> cur_len == sdf_pkg::DEC_LEN[cfg.rate])
        else $error("rejection applied outside low rates");
    rej_both_a: assert property (
        (cfg.rate == 3'h0 && !turbo && cfg.rej == sdf_pkg::REJ_BOTH)
        |-> cur_len == sdf_pkg::DEC_BOTH)
        else $error("dual rejection length wrong");
    bypass_gain_a: assert property (
        amp_bypass |-> cfg.gain <= sdf_pkg::GAIN_MAX_BYP && !low_noise_amp_en)
        else $error("bypass at a disallowed gain");
    bypass_sel_a: assert property (
        wr_ctrl && ctrl_merged[10] && ctrl_merged[9:7] <= sdf_pkg::GAIN_MAX_BYP
        |=> amp_bypass)
        else $error("bypass request not honoured");
    overrun_set_a: assert property (
        dec_done && res_valid && !buf_ready |=> overrun)
        else $error("lost result not flagged");
    wr_resp_a: assert property (
        do_wr |=> s_axi_bvalid)
        else $error("write response missing");

    result_c:  cover property (dec_done);
    turbo_c:   cover property (mod_clk_en && turbo);
    bypass_c:  cover property (amp_bypass);
    overrun_c: cover property (overrun);

endmodule : sdf_top

// File: bench/sdf_mod_src.sv
// Behavioural modulator bitstream source facing the decimation filter.
`timescale 1ns/10ps
module sdf_mod_src (
    // Clock
    input  logic clk,
    // Strobe from the filter and pattern choice
    input  logic mod_clk_en,
    input  logic level,
    input  logic alt,
    // Bitstream
    output logic mod_bit
);
    logic en_seen = 1'h0;

    initial mod_bit = 1'h0;

    // The strobe is looked at mid-cycle, so a toggle lands after the edge that takes the bit.
    always @(negedge clk) en_seen <= mod_clk_en;

    always @(posedge clk) begin
        if (!alt) mod_bit <= level;
        else if (en_seen) mod_bit <= ~mod_bit;
    end
endmodule : sdf_mod_src

// File: bench/tb_sdf_top.sv
// Self-checking testbench of the decimation filter block.
`timescale 1ns/10ps
module tb_sdf_top;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        ext_clk_active = 1'h0, level = 1'h0, alt = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        mod_bit, mod_clk_en, amp_bypass, low_noise_amp_en;
    logic [2:0]  gain;
    logic [31:0] rd, cw;
    int          n_errors = 0, checks = 0, seed = 48537, gap = 0, last_gap = 0;
    int          m, r, j, p;

    always #12.5 clk = ~clk;

    sdf_top u_sdf_top (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mod_bit, .mod_clk_en,
        .ext_clk_active, .amp_bypass, .low_noise_amp_en, .gain);

    sdf_mod_src u_sdf_mod_src (.clk, .mod_clk_en, .level, .alt, .mod_bit);

    // Strobe spacing, counted on falling edges where the strobe has settled.
    always @(negedge clk) begin
        if (mod_clk_en) begin
            last_gap = gap + 1;
            gap = 0;
        end else gap++;
    end

    // ----------------------------------------------------------------
    // Compare, verdict and bus tasks
    // ----------------------------------------------------------------
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_pin(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check_pin

    task automatic print_verdict;
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // Handshakes are judged at the falling edge, so the rising edge that follows is the take.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, done;
        done = 1'h0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        repeat (64) begin
            if (!done) begin
                @(negedge clk);
                aw = s_axi_awvalid & s_axi_awready;
                w = s_axi_wvalid & s_axi_wready;
                done = s_axi_bvalid;
                resp = s_axi_bresp;
                @(posedge clk);
                if (aw) s_axi_awvalid <= 1'h0;
                if (w) s_axi_wvalid <= 1'h0;
                if (done) s_axi_bready <= 1'h0;
            end
        end
        if (!done) n_errors++;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        logic ar, done;
        done = 1'h0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        repeat (64) begin
            if (!done) begin
                @(negedge clk);
                ar = s_axi_arvalid & s_axi_arready;
                done = s_axi_rvalid;
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                @(posedge clk);
                if (ar) s_axi_arvalid <= 1'h0;
                if (done) s_axi_rready <= 1'h0;
            end
        end
        if (!done) n_errors++;
    endtask : axi_read

    function automatic logic [31:0] ctrl(input int m, r, j, g, b, s);
        sdf_pkg::sdf_cfg_t c;
        c.mode = m[1:0];
        c.rate = r[2:0];
        c.rej = j[1:0];
        c.gain = g[2:0];
        c.amp_bypass = b[0];
        c.start = s[0];
        return {20'h00000, c};
    endfunction : ctrl

    // Sum of +1/-1 over one decimation length; pattern 0 low, 1 high, 2 alternating.
    function automatic logic [31:0] exp_result(input int r, input int p);
        logic [15:0] s;
        s = (r == 5) ? 16'h01AB : 16'h0100;
        if (p == 2) s = 16'h0000;
        else if (p == 0) s = -s;
        return {8'h00, {8{s[15]}}, s};
    endfunction : exp_result

    task automatic take_result(input logic [31:0] exp);
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[sdf_pkg::ST_AVAIL] !== 1'h1 && n < 3000) begin
            axi_read(sdf_pkg::ADDR_STATUS);
            n++;
        end
        if (n >= 3000) n_errors++;
        axi_read(sdf_pkg::ADDR_DATA);
        check_word("result", exp, rd & 32'h00FFFFFF);
    endtask : take_result

    // Stops conversions and empties whatever the buffer still holds.
    task automatic stop_drain;
        axi_write(sdf_pkg::ADDR_CTRL, 32'h0);
        repeat (4) begin
            axi_read(sdf_pkg::ADDR_STATUS);
            if (rd[sdf_pkg::ST_AVAIL] === 1'h1) axi_read(sdf_pkg::ADDR_DATA);
        end
    endtask : stop_drain

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        check_pin("amp_bypass", 1'h0, amp_bypass);
        check_pin("low_noise_amp_en", 1'h1, low_noise_amp_en);
        for (int e = 0; e < 2; e++) begin
            ext_clk_active <= e[0];
            axi_read(sdf_pkg::ADDR_STATUS);
            check_pin("status ext clock", e[0], rd[sdf_pkg::ST_EXTCLK]);
        end
        for (int k = 0; k < 4; k++) begin
            axi_write(sdf_pkg::ADDR_CTRL, ctrl(k, 6, 0, 0, 0, 0));
            repeat (40) @(posedge clk);
            check_word("strobe gap", (k == 2) ? 32'h8 : 32'h10, last_gap);
        end
        for (int k = 0; k < 16; k++) begin
            axi_write(sdf_pkg::ADDR_CTRL, ctrl(0, 6, 0, k % 8, k / 8, 0));
            @(negedge clk);
            check_pin("amp_bypass", (k / 8 == 1) && (k % 8 <= 2), amp_bypass);
            check_pin("low_noise_amp_en", !((k / 8 == 1) && (k % 8 <= 2)), low_noise_amp_en);
            check_word("gain", k % 8, {29'h0, gain});
            axi_read(sdf_pkg::ADDR_STATUS);
            check_pin("status bypass", (k / 8 == 1) && (k % 8 <= 2), rd[sdf_pkg::ST_BYPASS]);
        end
        axi_read(8'h0C);
        check_word("unmapped read", {30'h0, sdf_pkg::RESP_SLVERR}, {30'h0, resp});
        axi_write(8'h0C, 32'h0);
        check_word("unmapped write", {30'h0, sdf_pkg::RESP_SLVERR}, {30'h0, resp});
        axi_write(sdf_pkg::ADDR_DATA, 32'h0);
        check_word("data write", {30'h0, sdf_pkg::RESP_SLVERR}, {30'h0, resp});
        // Back-to-back results, then an alternating stream in turbo mode.
        level <= 1'h1;
        axi_write(sdf_pkg::ADDR_CTRL, ctrl(0, 6, 0, 2, 0, 1));
        take_result(exp_result(6, 1));
        take_result(exp_result(6, 1));
        stop_drain();
        alt <= 1'h1;
        axi_write(sdf_pkg::ADDR_CTRL, ctrl(2, 7, 0, 0, 0, 1));
        take_result(exp_result(7, 2));
        stop_drain();
        for (int k = 0; k < 4; k++) begin
            m = $unsigned($random(seed)) % 3;
            r = 5 + ($unsigned($random(seed)) % 3);
            j = $random(seed) & 3;
            p = (r == 5) ? ($random(seed) & 1) : ($unsigned($random(seed)) % 3);
            level <= (p == 1);
            alt <= (p == 2);
            cw = ctrl(m, r, j, $random(seed) & 7, 0, 1);
            axi_write(sdf_pkg::ADDR_CTRL, cw);
            axi_read(sdf_pkg::ADDR_CTRL);
            check_word("ctrl readback", cw, rd & 32'h00000FFF);
            take_result(exp_result(r, p));
            stop_drain();
        end
        // Four results unread: two buffered, one held, the fourth overruns.
        level <= 1'h1;
        alt <= 1'h0;
        axi_write(sdf_pkg::ADDR_CTRL, ctrl(2, 6, 0, 0, 0, 1));
        repeat (4 * 2048 + 300) @(posedge clk);
        axi_write(sdf_pkg::ADDR_CTRL, 32'h0);
        axi_read(sdf_pkg::ADDR_STATUS);
        check_word("status full", 32'h3, rd & 32'h3);
        repeat (3) begin
            axi_read(sdf_pkg::ADDR_DATA);
            check_word("kept result", exp_result(6, 1), rd & 32'h00FFFFFF);
        end
        axi_read(sdf_pkg::ADDR_STATUS);
        check_word("status empty", 32'h2, rd & 32'h3);
        axi_write(sdf_pkg::ADDR_STATUS, 32'h2);
        axi_read(sdf_pkg::ADDR_STATUS);
        check_word("status cleared", 32'h0, rd & 32'h3);
        print_verdict();
    end

    initial begin
        #(95000 * 25);
        n_errors++;
        print_verdict();
    end
endmodule : tb_sdf_top
